// *** pkg/aod_pkg.sv ***
package aod_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the AXI4-Lite bus).
	// ----------------------------------------------------------------
	localparam logic [7:0] AOD_OFS_CTRL   = 8'h00; // Enable and clear.
	localparam logic [7:0] AOD_OFS_OPC    = 8'h04; // Opcode byte and addressing byte in.
	localparam logic [7:0] AOD_OFS_RESULT = 8'h08; // Last decoded operation.
	localparam logic [7:0] AOD_OFS_CYCLES = 8'h0C; // Clock counts of last decode.
	localparam logic [7:0] AOD_OFS_STATUS = 8'h10; // Counters and pending override.

	localparam logic [1:0] AOD_RESP_OKAY   = 2'h0; // Normal answer.
	localparam logic [1:0] AOD_RESP_SLVERR = 2'h2; // Unmapped address.

	// ----------------------------------------------------------------
	// Fixed single-byte codes.
	// ----------------------------------------------------------------
	localparam logic [7:0] AOD_OP_SEG_CODE  = 8'h2E; // Override to code segment.
	localparam logic [7:0] AOD_OP_SEG_STACK = 8'h36; // Override to stack segment.
	localparam logic [7:0] AOD_OP_SEG_DATA  = 8'h3E; // Override to data segment.
	localparam logic [7:0] AOD_OP_SEG_EXTRA = 8'h26; // Override to extra segment.
	localparam logic [7:0] AOD_OP_ASCII_ADD = 8'h37; // Ascii sum fixup.
	localparam logic [7:0] AOD_OP_BCD_ADD   = 8'h27; // Bcd sum fixup.
	localparam logic [7:0] AOD_OP_ASCII_SUB = 8'h3F; // Ascii difference fixup.
	localparam logic [7:0] AOD_OP_BCD_SUB   = 8'h2F; // Bcd difference fixup.

	// High six bits of the two-operand register/memory forms.
	localparam logic [5:0] AOD_HI_ADD = 6'h00; // 000000dw.
	localparam logic [5:0] AOD_HI_ADC = 6'h04; // 000100dw.
	localparam logic [5:0] AOD_HI_SUB = 6'h0A; // 001010dw.
	localparam logic [5:0] AOD_HI_SBB = 6'h06; // 000110dw.
	localparam logic [5:0] AOD_HI_CMP = 6'h0E; // 0011100w and 0011101w.
	localparam logic [5:0] AOD_HI_IMM = 6'h20; // 100000sw.
	// High seven bits of the accumulator forms and unary groups.
	localparam logic [6:0] AOD_H7_ADD_ACC = 7'h02; // 0000010w.
	localparam logic [6:0] AOD_H7_ADC_ACC = 7'h0A; // 0001010w.
	localparam logic [6:0] AOD_H7_SBB_ACC = 7'h0E; // 0001110w.
	localparam logic [6:0] AOD_H7_CMP_ACC = 7'h1E; // 0011110w.
	localparam logic [6:0] AOD_H7_UNARY   = 7'h7B; // 1111011w.
	localparam logic [6:0] AOD_H7_STEP    = 7'h7F; // 1111111w.
	// High five bits of the short register forms.
	localparam logic [4:0] AOD_H5_INC_REG = 5'h08; // 01000reg.
	localparam logic [4:0] AOD_H5_DEC_REG = 5'h09; // 01001reg.

	// Second operand field values in the addressing byte.
	localparam logic [2:0] AOD_SUB_ADD = 3'h0;
	localparam logic [2:0] AOD_SUB_DEC = 3'h1;
	localparam logic [2:0] AOD_SUB_ADC = 3'h2;
	localparam logic [2:0] AOD_SUB_SBB = 3'h3;
	localparam logic [2:0] AOD_SUB_NEG = 3'h3;
	localparam logic [2:0] AOD_SUB_MUL = 3'h4;
	localparam logic [2:0] AOD_SUB_SUB = 3'h5;
	localparam logic [2:0] AOD_SUB_CMP = 3'h7;
	localparam logic [1:0] AOD_MOD_REG = 2'h3; // Addressing mode: register operand.
	localparam logic [1:0] AOD_SW_SEXT = 2'h3; // One sign-extended data byte.

	// Minimum clock counts.
	localparam logic [7:0] AOD_CLK_PREFIX  = 8'd2;
	localparam logic [7:0] AOD_CLK_RR      = 8'd3;
	localparam logic [7:0] AOD_CLK_RM      = 8'd10;
	localparam logic [7:0] AOD_CLK_IMM_R   = 8'd4;
	localparam logic [7:0] AOD_CLK_IMM_M   = 8'd16;
	localparam logic [7:0] AOD_CLK_ACC_B   = 8'd3;
	localparam logic [7:0] AOD_CLK_ACC_W   = 8'd4;
	localparam logic [7:0] AOD_CLK_STEP_M  = 8'd15;
	localparam logic [7:0] AOD_CLK_STEP_R  = 8'd3;
	localparam logic [7:0] AOD_CLK_AAA     = 8'd8;
	localparam logic [7:0] AOD_CLK_DAA     = 8'd4;
	localparam logic [7:0] AOD_CLK_AAS     = 8'd7;
	localparam logic [7:0] AOD_CLK_DAS     = 8'd4;
	localparam logic [7:0] AOD_CLK_MUL_RB  = 8'd26;
	localparam logic [7:0] AOD_CLK_MUL_RW  = 8'd35;
	localparam logic [7:0] AOD_CLK_MUL_MB  = 8'd32;
	localparam logic [7:0] AOD_CLK_MUL_MW  = 8'd41;
	localparam logic [7:0] AOD_MUL_SPREAD  = 8'd2; // Max minus min for multiply.

	// Decoded operation select.
	typedef enum logic [3:0] {
		AOD_OP_NONE     = 4'h0,
		AOD_OP_SEGMENT  = 4'h1,
		AOD_OP_SUM      = 4'h2,
		AOD_OP_SUMC     = 4'h3,
		AOD_OP_DIFF     = 4'h4,
		AOD_OP_DIFFB    = 4'h5,
		AOD_OP_CMP      = 4'h6,
		AOD_OP_STEPUP   = 4'h7,
		AOD_OP_STEPDN   = 4'h8,
		AOD_OP_SIGNFLIP = 4'h9,
		AOD_OP_AAA      = 4'hA,
		AOD_OP_DAA      = 4'hB,
		AOD_OP_AAS      = 4'hC,
		AOD_OP_DAS      = 4'hD,
		AOD_OP_MUL      = 4'hE
	} aod_op_e;

	// Operand form.
	typedef enum logic [2:0] {
		AOD_FM_NONE    = 3'h0,
		AOD_FM_REGMEM  = 3'h1,
		AOD_FM_IMM_RM  = 3'h2,
		AOD_FM_ACC_IMM = 3'h3,
		AOD_FM_SHORT   = 3'h4,
		AOD_FM_SINGLE  = 3'h5
	} aod_form_e;

	// Segment selected by an override.
	typedef enum logic [2:0] {
		AOD_SEG_DEFAULT = 3'h0,
		AOD_SEG_CODE    = 3'h1,
		AOD_SEG_STACK   = 3'h2,
		AOD_SEG_DATA    = 3'h3,
		AOD_SEG_EXTRA   = 3'h4
	} aod_seg_e;

endpackage : aod_pkg

// *** src/aod_decode_core.sv ***
`timescale 1ns/100ps
// Pure combinational decode of one opcode byte and its addressing byte.
module aod_decode_core
	import aod_pkg::*;
(
	input  wire logic [7:0]   opcode,
	input  wire logic [7:0]   modrm,
	output aod_op_e           op,
	output aod_form_e         form,
	output aod_seg_e          seg,
	output logic              word,
	output logic              dir_or_sext,
	output logic              needs_modrm,
	output logic [1:0]        imm_bytes,
	output logic [7:0]        clk_min_reg,
	output logic [7:0]        clk_min_mem,
	output logic              legal
);

	// ----------------------------------------------------------------
	// Field extraction.
	// ----------------------------------------------------------------
	logic [2:0] sub_field; // Second operand field of the addressing byte.
	logic       reg_mode;  // Addressing byte names a register operand.
	assign sub_field = modrm[5:3];
	assign reg_mode  = (modrm[7:6] == AOD_MOD_REG);

	// ----------------------------------------------------------------
	// Decode table.
	// ----------------------------------------------------------------
	// All outputs are given defaults first so unknown codes fall out as
	// illegal with no operation rather than a stale or partial decode.
	always_comb
	begin
		op          = AOD_OP_NONE;
		form        = AOD_FM_NONE;
		seg         = AOD_SEG_DEFAULT;
		word        = opcode[0];
		dir_or_sext = opcode[1];
		needs_modrm = 1'b0;
		imm_bytes   = 2'd0;
		clk_min_reg = 8'd0;
		clk_min_mem = 8'd0;
		legal       = 1'b1;
		if (opcode == AOD_OP_SEG_CODE || opcode == AOD_OP_SEG_STACK ||
			opcode == AOD_OP_SEG_DATA || opcode == AOD_OP_SEG_EXTRA)
		begin
			op          = AOD_OP_SEGMENT;
			form        = AOD_FM_SINGLE;
			clk_min_reg = AOD_CLK_PREFIX;
			clk_min_mem = AOD_CLK_PREFIX;
			word        = 1'b0;
			dir_or_sext = 1'b0;
			// Each prefix maps to one segment.
			if (opcode == AOD_OP_SEG_CODE)
				seg = AOD_SEG_CODE;
			else if (opcode == AOD_OP_SEG_STACK)
				seg = AOD_SEG_STACK;
			else if (opcode == AOD_OP_SEG_DATA)
				seg = AOD_SEG_DATA;
			else
				seg = AOD_SEG_EXTRA;
		end
		else if (opcode == AOD_OP_ASCII_ADD || opcode == AOD_OP_BCD_ADD ||
			opcode == AOD_OP_ASCII_SUB || opcode == AOD_OP_BCD_SUB)
		begin
			form        = AOD_FM_SINGLE;
			word        = 1'b0;
			dir_or_sext = 1'b0;
			if (opcode == AOD_OP_ASCII_ADD)
			begin
				op          = AOD_OP_AAA;
				clk_min_reg = AOD_CLK_AAA;
			end
			else if (opcode == AOD_OP_BCD_ADD)
			begin
				op          = AOD_OP_DAA;
				clk_min_reg = AOD_CLK_DAA;
			end
			else if (opcode == AOD_OP_ASCII_SUB)
			begin
				op          = AOD_OP_AAS;
				clk_min_reg = AOD_CLK_AAS;
			end
			else
			begin
				op          = AOD_OP_DAS;
				clk_min_reg = AOD_CLK_DAS;
			end
			clk_min_mem = clk_min_reg;
		end
		else if (opcode[7:2] == AOD_HI_ADD || opcode[7:2] == AOD_HI_ADC ||
			opcode[7:2] == AOD_HI_SUB || opcode[7:2] == AOD_HI_SBB ||
			opcode[7:2] == AOD_HI_CMP)
		begin
			// Two-operand register/memory form; bit 1 is the direction.
			form        = AOD_FM_REGMEM;
			needs_modrm = 1'b1;
			clk_min_reg = AOD_CLK_RR;
			clk_min_mem = AOD_CLK_RM;
			if (opcode[7:2] == AOD_HI_ADD)
				op = AOD_OP_SUM;
			else if (opcode[7:2] == AOD_HI_ADC)
				op = AOD_OP_SUMC;
			else if (opcode[7:2] == AOD_HI_SUB)
				op = AOD_OP_DIFF;
			else if (opcode[7:2] == AOD_HI_SBB)
				op = AOD_OP_DIFFB;
			else
				op = AOD_OP_CMP;
		end
		else if (opcode[7:2] == AOD_HI_IMM)
		begin
			// Immediate group; sw of 11 carries one sign-extended byte.
			form        = AOD_FM_IMM_RM;
			needs_modrm = 1'b1;
			imm_bytes   = (opcode[1:0] == 2'b01) ? 2'd2 : 2'd1;
			clk_min_reg = AOD_CLK_IMM_R;
			clk_min_mem = AOD_CLK_IMM_M;
			unique case (sub_field)
				AOD_SUB_ADD: op = AOD_OP_SUM;
				AOD_SUB_ADC: op = AOD_OP_SUMC;
				AOD_SUB_SUB: op = AOD_OP_DIFF;
				AOD_SUB_SBB: op = AOD_OP_DIFFB;
				AOD_SUB_CMP:
				begin
					// Compare with an immediate costs the reg/mem figures.
					op          = AOD_OP_CMP;
					clk_min_reg = AOD_CLK_RR;
					clk_min_mem = AOD_CLK_RM;
				end
				default:
				begin
					// Logic operations live in another decoder.
					legal       = 1'b0;
					form        = AOD_FM_NONE;
					needs_modrm = 1'b0;
					imm_bytes   = 2'd0;
					clk_min_reg = 8'd0;
					clk_min_mem = 8'd0;
				end
			endcase
		end
		else if (opcode[7:1] == AOD_H7_ADD_ACC || opcode[7:1] == AOD_H7_ADC_ACC ||
			opcode[7:1] == AOD_H7_SBB_ACC || opcode[7:1] == AOD_H7_CMP_ACC)
		begin
			// Accumulator immediate: 3 clocks byte, 4 clocks word.
			form        = AOD_FM_ACC_IMM;
			imm_bytes   = opcode[0] ? 2'd2 : 2'd1;
			clk_min_reg = opcode[0] ? AOD_CLK_ACC_W : AOD_CLK_ACC_B;
			clk_min_mem = clk_min_reg;
			dir_or_sext = 1'b0;
			if (opcode[7:1] == AOD_H7_ADD_ACC)
				op = AOD_OP_SUM;
			else if (opcode[7:1] == AOD_H7_ADC_ACC)
				op = AOD_OP_SUMC;
			else if (opcode[7:1] == AOD_H7_SBB_ACC)
				op = AOD_OP_DIFFB;
			else
				op = AOD_OP_CMP;
		end
		else if (opcode[7:1] == AOD_H7_STEP &&
			(sub_field == AOD_SUB_ADD || sub_field == AOD_SUB_DEC))
		begin
			form        = AOD_FM_REGMEM;
			needs_modrm = 1'b1;
			clk_min_reg = AOD_CLK_STEP_R;
			clk_min_mem = AOD_CLK_STEP_M;
			op          = (sub_field == AOD_SUB_ADD) ? AOD_OP_STEPUP : AOD_OP_STEPDN;
		end
		else if (opcode[7:3] == AOD_H5_INC_REG || opcode[7:3] == AOD_H5_DEC_REG)
		begin
			// Short register forms always act on a word register.
			form        = AOD_FM_SHORT;
			word        = 1'b1;
			dir_or_sext = 1'b0;
			clk_min_reg = AOD_CLK_STEP_R;
			clk_min_mem = AOD_CLK_STEP_R;
			op          = (opcode[7:3] == AOD_H5_INC_REG) ? AOD_OP_STEPUP : AOD_OP_STEPDN;
		end
		else if (opcode[7:1] == AOD_H7_UNARY && sub_field == AOD_SUB_NEG)
		begin
			form        = AOD_FM_REGMEM;
			needs_modrm = 1'b1;
			op          = AOD_OP_SIGNFLIP;
			clk_min_reg = AOD_CLK_RR;
			clk_min_mem = AOD_CLK_RM;
		end
		else if (opcode[7:1] == AOD_H7_UNARY && sub_field == AOD_SUB_MUL)
		begin
			form        = AOD_FM_REGMEM;
			needs_modrm = 1'b1;
			op          = AOD_OP_MUL;
			clk_min_reg = opcode[0] ? AOD_CLK_MUL_RW : AOD_CLK_MUL_RB;
			clk_min_mem = opcode[0] ? AOD_CLK_MUL_MW : AOD_CLK_MUL_MB;
		end
		else
		begin
			legal = 1'b0;
		end
		// Unused for anything but reg/mem forms; keeps the figure honest.
		if (needs_modrm && reg_mode)
			clk_min_mem = clk_min_reg;
	end

endmodule : aod_decode_core

// *** src/aod_arith_opcode_decoder.sv ***
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module aod_arith_opcode_decoder
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  q_byte,
	input  wire logic [7:0]  q_modrm,
	input  wire logic        q_valid,
	output logic             q_ready,
	output logic             eu_valid,
	output aod_pkg::aod_op_e eu_op,
	output aod_pkg::aod_form_e eu_form,
	output aod_pkg::aod_seg_e  eu_seg,
	output logic             eu_word,
	output logic [7:0]       eu_clocks
);
	import aod_pkg::*;

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	logic        en_r, en_nxt;             // Decoder enabled from the queue.
	logic [15:0] sw_opc_r, sw_opc_nxt;     // Software-written opcode pair.
	logic        sw_go_r, sw_go_nxt;       // Software decode request pending.
	logic [31:0] res_r, res_nxt;           // Result word for readback.
	logic [15:0] cyc_r, cyc_nxt;           // Reg/mem clock figures.
	logic [7:0]  ndec_r, ndec_nxt;         // Decodes done.
	logic [7:0]  nill_r, nill_nxt;         // Illegal bytes seen.
	aod_seg_e    pend_r, pend_nxt;         // Override waiting for next instruction.
	logic        q_ready_r, q_ready_nxt;
	logic        eu_valid_r, eu_valid_nxt;
	aod_op_e     eu_op_r, eu_op_nxt;
	aod_form_e   eu_form_r, eu_form_nxt;
	aod_seg_e    eu_seg_r, eu_seg_nxt;
	logic        eu_word_r, eu_word_nxt;
	logic [7:0]  eu_clk_r, eu_clk_nxt;
	// Bus state.
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0]  aw_a_r, aw_a_nxt;
	logic [31:0] w_d_r, w_d_nxt;
	logic [3:0]  w_s_r, w_s_nxt;
	logic        bv_r, bv_nxt, rv_r, rv_nxt, awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
	logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;

	// ----------------------------------------------------------------
	// Decoder instance.
	// ----------------------------------------------------------------
	logic       use_sw;     // Software request takes the decoder this cycle.
	logic [7:0] dec_opc, dec_mrm;
	aod_op_e    d_op;
	aod_form_e  d_form;
	aod_seg_e   d_seg;
	logic       d_word, d_dir, d_mrm, d_legal;
	logic [1:0] d_imm;
	logic [7:0] d_creg, d_cmem;
	assign use_sw  = sw_go_r;
	assign dec_opc = use_sw ? sw_opc_r[7:0] : q_byte;
	assign dec_mrm = use_sw ? sw_opc_r[15:8] : q_modrm;

	aod_decode_core u_core (
		.opcode      (dec_opc),
		.modrm       (dec_mrm),
		.op          (d_op),
		.form        (d_form),
		.seg         (d_seg),
		.word        (d_word),
		.dir_or_sext (d_dir),
		.needs_modrm (d_mrm),
		.imm_bytes   (d_imm),
		.clk_min_reg (d_creg),
		.clk_min_mem (d_cmem),
		.legal       (d_legal)
	);

	// ----------------------------------------------------------------
	// Decode pipeline.
	// ----------------------------------------------------------------
	// A decode happens on a software request, or on a queue byte while
	// enabled. Software wins, so the queue is simply held off that cycle.
	logic take_q, fire, wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	assign take_q = q_valid && q_ready_r && !use_sw;
	assign fire   = take_q || use_sw;
	always_comb
	begin
		eu_valid_nxt = 1'b0;
		eu_op_nxt    = eu_op_r;
		eu_form_nxt  = eu_form_r;
		eu_seg_nxt   = eu_seg_r;
		eu_word_nxt  = eu_word_r;
		eu_clk_nxt   = eu_clk_r;
		pend_nxt     = pend_r;
		res_nxt      = res_r;
		cyc_nxt      = cyc_r;
		ndec_nxt     = ndec_r;
		nill_nxt     = nill_r;
		q_ready_nxt  = en_r && !(sw_go_nxt);
		if (fire)
		begin
			if (!d_legal)
				nill_nxt = nill_r + 8'd1;
			else
			begin
				ndec_nxt     = ndec_r + 8'd1;
				eu_valid_nxt = 1'b1;
				eu_op_nxt    = d_op;
				eu_form_nxt  = d_form;
				eu_word_nxt  = d_word;
				// Memory figure when the addressing byte names memory.
				eu_clk_nxt   = (d_mrm && dec_mrm[7:6] != AOD_MOD_REG) ? d_cmem : d_creg;
				cyc_nxt      = {d_cmem, d_creg};
				res_nxt      = {11'h000, d_legal, d_mrm, d_imm, d_dir,
					d_word, d_form, d_seg, 1'b0, 4'h0, d_op};
				if (d_op == AOD_OP_SEGMENT)
				begin
					// Override holds until the next real instruction uses it.
					pend_nxt   = d_seg;
					eu_seg_nxt = d_seg;
				end
				else
				begin
					eu_seg_nxt = pend_r;
					pend_nxt   = AOD_SEG_DEFAULT;
				end
			end
		end
		if (wr_fire && wr_addr == AOD_OFS_CTRL && wr_data[1])
		begin
			ndec_nxt = 8'h00;
			nill_nxt = 8'h00;
			if (!(fire && d_legal && d_op == AOD_OP_SEGMENT)) // Set wins.
				pend_nxt = AOD_SEG_DEFAULT;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel.
	// ----------------------------------------------------------------
	// Address and data are captured in either order; the write lands
	// once both are held and no response is still outstanding.
	assign wr_fire = aw_got_r && w_got_r && !bv_r;
	assign wr_addr = aw_a_r;
	assign wr_data = w_d_r;
	always_comb
	begin
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		aw_a_nxt   = aw_a_r;
		w_d_nxt    = w_d_r;
		w_s_nxt    = w_s_r;
		bv_nxt     = bv_r;
		br_nxt     = br_r;
		en_nxt     = en_r;
		sw_opc_nxt = sw_opc_r;
		sw_go_nxt  = 1'b0;
		if (s_axi_awvalid && awr_r)
		begin
			aw_got_nxt = 1'b1;
			aw_a_nxt   = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_r)
		begin
			w_got_nxt = 1'b1;
			w_d_nxt   = s_axi_wdata;
			w_s_nxt   = s_axi_wstrb;
		end
		if (bv_r && s_axi_bready)
			bv_nxt = 1'b0;
		if (wr_fire)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bv_nxt     = 1'b1;
			br_nxt     = AOD_RESP_OKAY;
			if (wr_addr == AOD_OFS_CTRL)
			begin
				if (w_s_r[0])
					en_nxt = wr_data[0];
			end
			else if (wr_addr == AOD_OFS_OPC)
			begin
				if (w_s_r[0])
					sw_opc_nxt[7:0] = wr_data[7:0];
				if (w_s_r[1])
					sw_opc_nxt[15:8] = wr_data[15:8];
				sw_go_nxt = 1'b1;
			end
			else if (wr_addr != AOD_OFS_RESULT && wr_addr != AOD_OFS_CYCLES &&
				wr_addr != AOD_OFS_STATUS)
				br_nxt = AOD_RESP_SLVERR;
		end
		awr_nxt = !aw_got_nxt;
		wr_nxt  = !w_got_nxt;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel.
	// ----------------------------------------------------------------
	always_comb
	begin
		rv_nxt  = rv_r;
		rr_nxt  = rr_r;
		rd_nxt  = rd_r;
		arr_nxt = arr_r;
		if (rv_r && s_axi_rready)
		begin
			rv_nxt  = 1'b0;
			arr_nxt = 1'b1;
		end
		if (s_axi_arvalid && arr_r)
		begin
			arr_nxt = 1'b0;
			rv_nxt  = 1'b1;
			rr_nxt  = AOD_RESP_OKAY;
			unique case (s_axi_araddr)
				AOD_OFS_CTRL:   rd_nxt = {31'h0, en_r};
				AOD_OFS_OPC:    rd_nxt = {16'h0, sw_opc_r};
				AOD_OFS_RESULT: rd_nxt = res_r;
				AOD_OFS_CYCLES: rd_nxt = {16'h0, cyc_r};
				AOD_OFS_STATUS: rd_nxt = {13'h0, pend_r, nill_r, ndec_r};
				default:
				begin
					rd_nxt = 32'h0;
					rr_nxt = AOD_RESP_SLVERR;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			en_r <= 1'b0; sw_opc_r <= 16'h0; sw_go_r <= 1'b0;
			res_r <= 32'h0; cyc_r <= 16'h0; ndec_r <= 8'h0; nill_r <= 8'h0;
			pend_r <= AOD_SEG_DEFAULT; q_ready_r <= 1'b0; eu_valid_r <= 1'b0;
			eu_op_r <= AOD_OP_NONE; eu_form_r <= AOD_FM_NONE;
			eu_seg_r <= AOD_SEG_DEFAULT; eu_word_r <= 1'b0; eu_clk_r <= 8'h0;
			aw_got_r <= 1'b0; w_got_r <= 1'b0; aw_a_r <= 8'h0; w_d_r <= 32'h0;
			w_s_r <= 4'h0; bv_r <= 1'b0; br_r <= 2'h0; rv_r <= 1'b0;
			rr_r <= 2'h0; rd_r <= 32'h0; awr_r <= 1'b1; wr_r <= 1'b1; arr_r <= 1'b1;
		end
		else
		begin
			en_r <= en_nxt; sw_opc_r <= sw_opc_nxt; sw_go_r <= sw_go_nxt;
			res_r <= res_nxt; cyc_r <= cyc_nxt; ndec_r <= ndec_nxt; nill_r <= nill_nxt;
			pend_r <= pend_nxt; q_ready_r <= q_ready_nxt; eu_valid_r <= eu_valid_nxt;
			eu_op_r <= eu_op_nxt; eu_form_r <= eu_form_nxt;
			eu_seg_r <= eu_seg_nxt; eu_word_r <= eu_word_nxt; eu_clk_r <= eu_clk_nxt;
			aw_got_r <= aw_got_nxt; w_got_r <= w_got_nxt; aw_a_r <= aw_a_nxt;
			w_d_r <= w_d_nxt; w_s_r <= w_s_nxt; bv_r <= bv_nxt; br_r <= br_nxt;
			rv_r <= rv_nxt; rr_r <= rr_nxt; rd_r <= rd_nxt;
			awr_r <= awr_nxt; wr_r <= wr_nxt; arr_r <= arr_nxt;
		end
	end

	// Outputs come straight from flip-flops.
	assign s_axi_awready = awr_r;
	assign s_axi_wready  = wr_r;
	assign s_axi_bvalid  = bv_r;
	assign s_axi_bresp   = br_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rresp   = rr_r;
	assign s_axi_rdata   = rd_r;
	assign q_ready       = q_ready_r;
	assign eu_valid      = eu_valid_r;
	assign eu_op         = eu_op_r;
	assign eu_form       = eu_form_r;
	assign eu_seg        = eu_seg_r;
	assign eu_word       = eu_word_r;
	assign eu_clocks     = eu_clk_r;

endmodule : aod_arith_opcode_decoder

// *** verification/aod_q_src.sv ***
`timescale 1ns/100ps
// Prefetch queue model: offers one opcode byte and its addressing byte.
module aod_q_src
(
	input  wire logic  aclk,
	input  wire logic  q_ready,
	output logic [7:0] q_byte,
	output logic [7:0] q_modrm,
	output logic       q_valid
);
	initial
	begin
		q_valid = 1'b0;
		q_byte  = 8'h00;
		q_modrm = 8'h00;
	end
	// Call just after an edge; the pair holds until the edge that takes it.
	task push(input logic [7:0] b, input logic [7:0] m);
		q_byte  <= b;
		q_modrm <= m;
		q_valid <= 1'b1;
		do @(posedge aclk); while (q_ready !== 1'b1);
		// Released lines flip, so a stale byte never looks like a fresh one.
		q_valid <= 1'b0;
		q_byte  <= ~b;
		q_modrm <= ~m;
	endtask : push
endmodule : aod_q_src

// *** verification/aod_arith_opcode_decoder_chk.sv ***
`timescale 1ns/100ps
// Decode checks tied to the byte taken from the queue.
module aod_arith_opcode_decoder_chk
	import aod_pkg::*;
(
	input wire logic           aclk,
	input wire logic           aresetn,
	input wire logic [7:0]     q_byte,
	input wire logic [7:0]     q_modrm,
	input wire logic           q_valid,
	input wire logic           q_ready,
	input wire logic           eu_valid,
	input wire aod_pkg::aod_op_e   eu_op,
	input wire aod_pkg::aod_form_e eu_form,
	input wire aod_pkg::aod_seg_e  eu_seg,
	input wire logic           eu_word,
	input wire logic [7:0]     eu_clocks
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic take = q_valid && q_ready; // Queue handshake.
	sequence pfx_data; take && q_byte == AOD_OP_SEG_DATA; endsequence
	sequence ascii_sub; take && q_byte == AOD_OP_ASCII_SUB; endsequence
	seg_code_a: assert property (take && q_byte == AOD_OP_SEG_CODE |=> eu_valid
		&& eu_op == AOD_OP_SEGMENT && eu_seg == AOD_SEG_CODE && eu_clocks == 8'd2) else $error("code override");
	seg_extra_a: assert property (take && q_byte == AOD_OP_SEG_EXTRA |=> eu_seg == AOD_SEG_EXTRA)
		else $error("extra override");
	seg_carry_a: assert property (pfx_data ##1 !take ##1 ascii_sub
		|=> eu_seg == AOD_SEG_DATA && eu_clocks == 8'd7) else $error("override not carried");
	sum_reg_a: assert property (take && q_byte[7:2] == AOD_HI_ADD && q_modrm[7:6] == 2'h3
		|=> eu_op == AOD_OP_SUM && eu_form == AOD_FM_REGMEM && eu_clocks == 8'd3) else $error("sum");
	width_bit_a: assert property (take && q_byte[7:2] == AOD_HI_SUB |=> eu_word == $past(q_byte[0]))
		else $error("width bit");
	diff_imm_a: assert property (take && q_byte[7:2] == AOD_HI_IMM && q_modrm[7:3] == 5'h05
		|=> eu_op == AOD_OP_DIFF && eu_clocks == 8'd16) else $error("difference immediate");
	step_dn_a: assert property (take && q_byte[7:3] == AOD_H5_DEC_REG |=> eu_op == AOD_OP_STEPDN
		&& eu_form == AOD_FM_SHORT && eu_clocks == 8'd3) else $error("step down");
	fix_clk_a: assert property (take && q_byte == AOD_OP_ASCII_ADD |=> eu_op == AOD_OP_AAA
		&& eu_clocks == 8'd8) else $error("ascii sum fixup");
	mul_reg_a: assert property (take && q_byte[7:1] == AOD_H7_UNARY && q_modrm[7:3] == 5'h1C
		|=> eu_clocks == ($past(q_byte[0]) ? 8'd35 : 8'd26)) else $error("product clocks");
endmodule : aod_arith_opcode_decoder_chk
bind aod_arith_opcode_decoder aod_arith_opcode_decoder_chk i_chk(.aclk(aclk), .aresetn(aresetn),
	.q_byte(q_byte), .q_modrm(q_modrm), .q_valid(q_valid), .q_ready(q_ready), .eu_valid(eu_valid),
	.eu_op(eu_op), .eu_form(eu_form), .eu_seg(eu_seg), .eu_word(eu_word), .eu_clocks(eu_clocks));

// *** verification/test_arith_opcode_decoder.sv ***
`timescale 1ns/100ps
module test_arith_opcode_decoder;
	import aod_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, q_valid, q_ready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, q_byte, q_modrm, eu_clocks;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [3:0] s_axi_wstrb;
	logic eu_word;
	aod_op_e eu_op;
	aod_form_e eu_form;
	aod_seg_e eu_seg;
	int bad_count, total_checks, cyc;
	aod_arith_opcode_decoder i_aod_arith_opcode_decoder(.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .q_byte, .q_modrm, .q_valid,
		.q_ready, .eu_valid(), .eu_op, .eu_form, .eu_seg, .eu_word, .eu_clocks);
	aod_q_src i_aod_q_src(.aclk, .q_ready, .q_byte, .q_modrm, .q_valid);
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Write: address and data offered together, each dropped when taken.
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw;
		@(posedge aclk);
		{pa, pw} = 2'b11;
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
		while (pa || pw)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) begin pa = 1'b0; s_axi_awvalid <= 1'b0; end
			if (s_axi_wready === 1'b1) begin pw = 1'b0; s_axi_wvalid <= 1'b0; end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task rdt(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask : rdt
	// Offer one pair from the queue, then judge the decoded result.
	task dq(input logic [31:0] t);
		i_aod_q_src.push(t[31:24], t[23:16]);
		@(posedge aclk);
		chk("eu_op", t[15:8], eu_op);
		chk("eu_clocks", t[7:0], eu_clocks);
	endtask : dq
	task t_regs;
		chk("q_ready off", 0, q_ready);
		wr(AOD_OFS_CTRL, 32'h1); chk("bresp", AOD_RESP_OKAY, rs);
		rdt(AOD_OFS_CTRL); chk("ctrl", 32'h1, rd);
		rdt(8'h40); chk("rresp", AOD_RESP_SLVERR, rs);
		wr(AOD_OFS_OPC, 0); rdt(AOD_OFS_CYCLES); chk("cycles", 32'h0A03, rd);
		$display("test regs done");
	endtask : t_regs
	// Opcode, addressing byte, operation, clocks for each decoded form.
	logic [31:0] tab [27] = '{32'h00C00203, 32'h83280410, 32'h05000204, 32'h14000303,
		32'h15000304, 32'h81100310, 32'h1800050A, 32'h1C000503, 32'h1D000504, 32'h83D80504,
		32'h2AC00403, 32'h3AC00603, 32'h3B00060A, 32'h8038060A, 32'h3D000604, 32'hFE08080F,
		32'h4B000803, 32'hFFC00703, 32'h40000703, 32'hF7D80903, 32'hF618090A, 32'h37000A08,
		32'h27000B04, 32'h3F000C07, 32'h2F000D04, 32'hF6E00E1A, 32'hF7200E29};
	task t_arith;
		foreach (tab[i]) dq(tab[i]);
		$display("test arith done");
	endtask : t_arith
	logic [7:0] pfx [4] = '{8'h2E, 8'h36, 8'h3E, 8'h26};
	task t_seg;
		foreach (pfx[i])
		begin
			dq({pfx[i], 16'h0001, 8'h02});
			chk("eu_seg", i + 1, eu_seg);
		end
		dq(32'h3E000102);
		dq(32'h3F000C07); chk("eu_seg", AOD_SEG_DATA, eu_seg);
		$display("test seg done");
	endtask : t_seg
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	always @(posedge aclk) if (++cyc == 4000) begin bad_count++; give_verdict(); end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_arith();
		t_seg();
		give_verdict();
	end
endmodule : test_arith_opcode_decoder
